// >>> logic/clock_state_pkg.sv
// Constants and state type for the processor clock-state manager.
// Assumes a single 125 MHz system clock shared with the host bus.
package clock_state_pkg;

   // ****************************************
   // Clock states
   // ****************************************
   typedef enum logic [2:0] {
      ST_NORMAL,
      ST_AUTO_HALT,
      ST_QUICK_START,
      ST_SNOOP,
      ST_DEEP_SLEEP,
      ST_RELOCK
   } clk_state_t;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 8;
   localparam int PLL_RELOCK_US = 30;
   localparam int EXIT_LIMIT_US = 10;
   // Longest times round down
   localparam int RELOCK_CYC = (PLL_RELOCK_US * 1000) / CLK_PERIOD_NS;
   localparam int EXIT_LIMIT_CYC = (EXIT_LIMIT_US * 1000) / CLK_PERIOD_NS;
   localparam int RELOCK_W = 12;
   localparam logic [RELOCK_W-1:0] RELOCK_LAST = RELOCK_W'(RELOCK_CYC - 1);
   localparam int SNOOP_EXIT_CYC = 2;
   localparam logic [1:0] SNOOP_LAST = 2'(SNOOP_EXIT_CYC - 1);

   // ****************************************
   // Synchroniser bit positions and idle values
   // ****************************************
   localparam int SYNC_W = 8;
   localparam int SB_STOP_N = 7;
   localparam int SB_DSLP_N = 6;
   localparam int SB_BCLK_RUN = 5;
   localparam int SB_NMI = 4;
   localparam int SB_INTR = 3;
   localparam int SB_BUS_INIT_N_N = 2;
   localparam int SB_FLUSH_N = 1;
   localparam int SB_SMI_N = 0;
   localparam logic [SYNC_W-1:0] SYNC_RST = 8'hE7;

endpackage

// >>> logic/cpu_clock_state_manager.sv
// Clock-state sequencer: Normal, Auto Halt, Quick Start, snoop and Deep Sleep.
// Assumes sys_clk is the host bus clock; control pins arrive asynchronously.
`timescale 1ns/100ps
`default_nettype none

module cpu_clock_state_manager (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic stop_clock_request_n,
   input wire logic deep_sleep_request_n,
   input wire logic bus_clock_running,
   input wire logic nmi,
   input wire logic intr,
   input wire logic bus_init_n,
   input wire logic flush_n,
   input wire logic sys_mgmt_interrupt_n,
   input wire logic cpu_reset_n,
   input wire logic halt_instruction,
   input wire logic snoop_request,
   input wire logic bus_quiet,
   output logic [2:0] clock_state,
   output logic core_clk_en,
   output logic snoop_grant,
   output logic counters_en,
   output logic pll_relocking,
   output logic halt_bus_cycle,
   output logic core_init
);

   // ****************************************
   // Input synchronisers
   // ****************************************
   logic [clock_state_pkg::SYNC_W-1:0] raw_in;
   logic [clock_state_pkg::SYNC_W-1:0] sync1_q;
   logic [clock_state_pkg::SYNC_W-1:0] sync2_q;

   assign raw_in = {stop_clock_request_n, deep_sleep_request_n, bus_clock_running, nmi, intr,
                    bus_init_n, flush_n, sys_mgmt_interrupt_n};

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_q <= clock_state_pkg::SYNC_RST;
         sync2_q <= clock_state_pkg::SYNC_RST;
      end else begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
      end
   end

   logic stop_req;
   logic dslp_req;
   logic bclk_run;
   logic break_ev;

   assign stop_req = !sync2_q[clock_state_pkg::SB_STOP_N];
   assign dslp_req = !sync2_q[clock_state_pkg::SB_DSLP_N];
   assign bclk_run = sync2_q[clock_state_pkg::SB_BCLK_RUN];
   assign break_ev = sync2_q[clock_state_pkg::SB_NMI] || sync2_q[clock_state_pkg::SB_INTR]
                     || !sync2_q[clock_state_pkg::SB_BUS_INIT_N_N] || !sync2_q[clock_state_pkg::SB_FLUSH_N]
                     || !sync2_q[clock_state_pkg::SB_SMI_N] || !cpu_reset_n;

   // ****************************************
   // State machine
   // ****************************************
   clock_state_pkg::clk_state_t state_q, state_d;
   clock_state_pkg::clk_state_t prev_q, prev_d;
   logic qs_from_halt_q, qs_from_halt_d;
   logic [clock_state_pkg::RELOCK_W-1:0] relock_cnt_q, relock_cnt_d;
   logic [1:0] snoop_cnt_q, snoop_cnt_d;
   logic halt_cycle_q, halt_cycle_d;
   logic core_init_q, core_init_d;

   always_comb begin
      state_d = state_q;
      prev_d = prev_q;
      qs_from_halt_d = qs_from_halt_q;
      relock_cnt_d = relock_cnt_q;
      snoop_cnt_d = snoop_cnt_q;
      halt_cycle_d = 1'b0;
      core_init_d = 1'b0;
      case (state_q)
         clock_state_pkg::ST_NORMAL: begin
            if (stop_req) begin
               state_d = clock_state_pkg::ST_QUICK_START;
               qs_from_halt_d = 1'b0;
            end else if (halt_instruction) begin
               // Halt entry issues one halt cycle
               state_d = clock_state_pkg::ST_AUTO_HALT;
               halt_cycle_d = 1'b1;
            end
         end
         clock_state_pkg::ST_AUTO_HALT: begin
            if (snoop_request) begin
               state_d = clock_state_pkg::ST_SNOOP;
               prev_d = clock_state_pkg::ST_AUTO_HALT;
               snoop_cnt_d = 2'h0;
            end else if (break_ev) begin
               state_d = clock_state_pkg::ST_NORMAL;
            end else if (stop_req) begin
               state_d = clock_state_pkg::ST_QUICK_START;
               qs_from_halt_d = 1'b1;
            end
         end
         clock_state_pkg::ST_QUICK_START: begin
            if (!cpu_reset_n) begin
               core_init_d = 1'b1;
            end else if (snoop_request) begin
               state_d = clock_state_pkg::ST_SNOOP;
               prev_d = clock_state_pkg::ST_QUICK_START;
               snoop_cnt_d = 2'h0;
            end else if (!bclk_run || dslp_req) begin
               state_d = clock_state_pkg::ST_DEEP_SLEEP;
            end else if (!stop_req) begin
               // Back to halt without halt cycle
               state_d = qs_from_halt_q ? clock_state_pkg::ST_AUTO_HALT : clock_state_pkg::ST_NORMAL;
            end
         end
         clock_state_pkg::ST_SNOOP: begin
            // Leave a few clocks after quiet
            if (bus_quiet) begin
               if (snoop_cnt_q == clock_state_pkg::SNOOP_LAST) begin
                  state_d = prev_q;
               end else begin
                  snoop_cnt_d = snoop_cnt_q + 2'h1;
               end
            end else begin
               snoop_cnt_d = 2'h0;
            end
         end
         clock_state_pkg::ST_DEEP_SLEEP: begin
            if (bclk_run && !dslp_req) begin
               state_d = clock_state_pkg::ST_RELOCK;
               relock_cnt_d = '0;
            end
         end
         clock_state_pkg::ST_RELOCK: begin
            if (relock_cnt_q == clock_state_pkg::RELOCK_LAST) begin
               state_d = clock_state_pkg::ST_QUICK_START;
            end else begin
               relock_cnt_d = relock_cnt_q + 12'h001;
            end
         end
         default: begin
            state_d = clock_state_pkg::ST_NORMAL;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= clock_state_pkg::ST_NORMAL;
         prev_q <= clock_state_pkg::ST_NORMAL;
         qs_from_halt_q <= 1'b0;
         relock_cnt_q <= '0;
         snoop_cnt_q <= 2'h0;
         halt_cycle_q <= 1'b0;
         core_init_q <= 1'b0;
      end else begin
         state_q <= state_d;
         prev_q <= prev_d;
         qs_from_halt_q <= qs_from_halt_d;
         relock_cnt_q <= relock_cnt_d;
         snoop_cnt_q <= snoop_cnt_d;
         halt_cycle_q <= halt_cycle_d;
         core_init_q <= core_init_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign clock_state = state_q;
   assign core_clk_en = (state_q == clock_state_pkg::ST_NORMAL);
   // No snoop grant in Deep Sleep
   assign snoop_grant = (state_q == clock_state_pkg::ST_SNOOP);
   assign counters_en = (state_q == clock_state_pkg::ST_NORMAL) || (state_q == clock_state_pkg::ST_AUTO_HALT)
                        || ((state_q == clock_state_pkg::ST_SNOOP) && (prev_q == clock_state_pkg::ST_AUTO_HALT));
   assign pll_relocking = (state_q == clock_state_pkg::ST_RELOCK);
   assign halt_bus_cycle = halt_cycle_q;
   assign core_init = core_init_q;

   // ****************************************
   // Assertions
   // ****************************************
   // Relock length counter
   logic [clock_state_pkg::RELOCK_W-1:0] relock_seen_q, relock_seen_d;

   always_comb begin
      relock_seen_d = '0;
      if (pll_relocking) begin
         relock_seen_d = relock_seen_q + 12'h001;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         relock_seen_q <= '0;
      end else begin
         relock_seen_q <= relock_seen_d;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   a_deep_sleep_entry: assert property (
      (state_q == clock_state_pkg::ST_QUICK_START) && cpu_reset_n && !snoop_request && (!bclk_run || dslp_req)
      |=> state_q == clock_state_pkg::ST_DEEP_SLEEP)
      else $error("Deep Sleep not entered from Quick Start");

   a_deep_sleep_exit: assert property (
      (state_q == clock_state_pkg::ST_DEEP_SLEEP) && bclk_run && !dslp_req
      |=> state_q == clock_state_pkg::ST_RELOCK)
      else $error("Deep Sleep exit not started");

   a_relock_count: assert property (
      pll_relocking |-> (relock_seen_q < clock_state_pkg::RELOCK_CYC))
      else $error("Relock wait too long");

   a_relock_done: assert property (
      $fell(pll_relocking) |-> (int'(relock_seen_q) == clock_state_pkg::RELOCK_CYC)
      && (state_q == clock_state_pkg::ST_QUICK_START))
      else $error("Relock wait length wrong");

   a_auto_halt_exit: assert property (
      (state_q == clock_state_pkg::ST_AUTO_HALT) && !snoop_request && break_ev
      |=> state_q == clock_state_pkg::ST_NORMAL)
      else $error("Auto Halt break not taken");

   a_quick_snoop: assert property (
      (state_q == clock_state_pkg::ST_QUICK_START) && cpu_reset_n && snoop_request |=> snoop_grant)
      else $error("Snoop not granted at once");

   a_snoop_leave: assert property (
      (snoop_grant && bus_quiet) [*2] |=> !snoop_grant && (state_q == $past(prev_q)))
      else $error("Snoop state not left after quiet");

   a_no_deep_snoop: assert property (
      (state_q == clock_state_pkg::ST_DEEP_SLEEP) && snoop_request |=> !snoop_grant)
      else $error("Snoop granted in Deep Sleep");

   a_counters_stop: assert property (
      (state_q == clock_state_pkg::ST_QUICK_START) |-> !counters_en)
      else $error("Counters run in Quick Start");

   a_sync_delay: assert property (
      $fell(stop_clock_request_n) ##2 (state_q == clock_state_pkg::ST_NORMAL)
      |=> (state_q == clock_state_pkg::ST_QUICK_START))
      else $error("Stop request not seen after two stages");

   a_halt_entry: assert property (
      (state_q == clock_state_pkg::ST_NORMAL) && !stop_req && halt_instruction
      |=> (state_q == clock_state_pkg::ST_AUTO_HALT) && halt_bus_cycle)
      else $error("Halt entry wrong");

   a_no_new_halt: assert property (
      (state_q == clock_state_pkg::ST_QUICK_START) && qs_from_halt_q && cpu_reset_n && !snoop_request
      && bclk_run && !dslp_req && !stop_req |=> (state_q == clock_state_pkg::ST_AUTO_HALT) && !halt_bus_cycle)
      else $error("Quick Start to halt return wrong");

   a_reset_holds: assert property (
      (state_q == clock_state_pkg::ST_QUICK_START) && !cpu_reset_n
      |=> (state_q == clock_state_pkg::ST_QUICK_START) && core_init)
      else $error("Reset left Quick Start");

   a_snoop_entry: assert property (
      (state_q == clock_state_pkg::ST_AUTO_HALT) && snoop_request
      |=> snoop_grant && (prev_q == clock_state_pkg::ST_AUTO_HALT))
      else $error("Auto Halt snoop not taken");

   c_deep_round: cover property (
      (state_q == clock_state_pkg::ST_DEEP_SLEEP) ##[1:20] pll_relocking);
   c_halt_snoop: cover property (
      (state_q == clock_state_pkg::ST_AUTO_HALT) ##1 snoop_grant ##[1:10] (state_q == clock_state_pkg::ST_AUTO_HALT));
   c_halt_stop: cover property (
      (state_q == clock_state_pkg::ST_AUTO_HALT) ##1 (state_q == clock_state_pkg::ST_QUICK_START));
   c_qs_reset: cover property (core_init);

endmodule

`default_nettype wire

// >>> test/chipset_model.sv
// Chipset model: drives stop, deep-sleep and bus clock pins.
// Assumes one bench process calls its tasks.
`timescale 1ns/100ps
`default_nettype none

module chipset_model (
   input wire logic sys_clk,
   output logic stop_clock_request_n,
   output logic deep_sleep_request_n,
   output logic bus_clock_running,
   output logic intc_clk_on
);
   initial begin
      stop_clock_request_n = 1'b1;
      deep_sleep_request_n = 1'b1;
      bus_clock_running = 1'b1;
      intc_clk_on = 1'b1;
   end

   task automatic deep(input logic by_clk, input logic on, input int gap);
      repeat (gap + 1) @(posedge sys_clk);
      intc_clk_on <= !on;
      if (by_clk) begin
         bus_clock_running <= !on;
      end else begin
         deep_sleep_request_n <= !on;
      end
   endtask

   task automatic stop(input logic on, input int gap);
      repeat (gap + 1) @(posedge sys_clk);
      stop_clock_request_n <= !on;
   endtask
endmodule

`default_nettype wire

// >>> test/cpu_clock_state_manager_tb_top.sv
// Testbench for the clock-state sequencer.
// Assumes the chipset model drives the async clock-control pins.
`timescale 1ns/100ps
`default_nettype none

module cpu_clock_state_manager_tb_top;
   localparam clock_state_pkg::clk_state_t NRM = clock_state_pkg::ST_NORMAL;
   localparam clock_state_pkg::clk_state_t AH = clock_state_pkg::ST_AUTO_HALT;
   localparam clock_state_pkg::clk_state_t QS = clock_state_pkg::ST_QUICK_START;
   localparam clock_state_pkg::clk_state_t SNP = clock_state_pkg::ST_SNOOP;
   localparam clock_state_pkg::clk_state_t DS = clock_state_pkg::ST_DEEP_SLEEP;
   localparam clock_state_pkg::clk_state_t RL = clock_state_pkg::ST_RELOCK;
   localparam int RLC = clock_state_pkg::RELOCK_CYC;
   logic sys_clk, arst_n, halt_instruction, snoop_request, bus_quiet;
   logic [5:0] brk;
   logic stop_n, dslp_n, bclk_run, intc_on;
   logic [2:0] clock_state;
   logic core_clk_en, snoop_grant, counters_en, pll_relocking, halt_bus_cycle, core_init;
   int num_errors, checked, n;

   chipset_model sysm (.sys_clk(sys_clk), .stop_clock_request_n(stop_n),
      .deep_sleep_request_n(dslp_n), .bus_clock_running(bclk_run), .intc_clk_on(intc_on));

   cpu_clock_state_manager uut (.sys_clk(sys_clk), .arst_n(arst_n), .stop_clock_request_n(stop_n),
      .deep_sleep_request_n(dslp_n), .bus_clock_running(bclk_run), .nmi(brk[0]), .intr(brk[1]),
      .bus_init_n(~brk[2]), .flush_n(~brk[3]), .sys_mgmt_interrupt_n(~brk[4]), .cpu_reset_n(~brk[5]),
      .halt_instruction(halt_instruction), .snoop_request(snoop_request), .bus_quiet(bus_quiet),
      .clock_state(clock_state), .core_clk_en(core_clk_en), .snoop_grant(snoop_grant),
      .counters_en(counters_en), .pll_relocking(pll_relocking), .halt_bus_cycle(halt_bus_cycle),
      .core_init(core_init));

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input logic ok, input string m);
      checked++;
      if (!ok) begin
         num_errors++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask

   task automatic go(input clock_state_pkg::clk_state_t s, input int lim);
      n = 0;
      while (clock_state !== s && n < lim) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
   endtask

   task automatic pulse_halt;
      @(posedge sys_clk);
      halt_instruction <= 1'b1;
      @(posedge sys_clk);
      halt_instruction <= 1'b0;
      #1;
   endtask

   task automatic set_brk(input logic [5:0] v);
      @(posedge sys_clk);
      brk <= v;
   endtask

   task automatic close_out;
      $display("checked %0d num_errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_halt;
      for (int i = 0; i < 6; i++) begin
         pulse_halt();
         chk(clock_state === AH && halt_bus_cycle === 1'b1 && core_clk_en === 1'b0, "halt entry");
         set_brk(6'(1 << i));
         go(NRM, 8);
         chk(clock_state === NRM && n <= 3 && halt_bus_cycle === 1'b0, "break exit");
         set_brk(6'h00);
         go(NRM, 3);
      end
      $display("test halt done");
   endtask

   task automatic t_stop_halt;
      pulse_halt();
      sysm.stop(1'b1, 0);
      go(QS, 6);
      chk(clock_state === QS && counters_en === 1'b0, "stop in halt");
      sysm.stop(1'b0, 5);
      go(AH, 6);
      chk(clock_state === AH && halt_bus_cycle === 1'b0, "back to halt");
      set_brk(6'h01);
      set_brk(6'h00);
      go(NRM, 6);
      $display("test stop_halt done");
   endtask

   task automatic t_snoop(input logic from_qs);
      clock_state_pkg::clk_state_t home;
      home = from_qs ? QS : AH;
      if (from_qs) begin
         sysm.stop(1'b1, 0);
         go(QS, 6);
      end else begin
         pulse_halt();
      end
      @(posedge sys_clk);
      snoop_request <= 1'b1;
      @(posedge sys_clk);
      snoop_request <= 1'b0;
      #1;
      chk(clock_state === SNP && snoop_grant === 1'b1, "snoop entry");
      repeat (3) @(posedge sys_clk);
      #1;
      chk(snoop_grant === 1'b1, "snoop held busy");
      @(posedge sys_clk);
      bus_quiet <= 1'b1;
      go(home, 4);
      chk(clock_state === home && n == 2 && snoop_grant === 1'b0, "snoop exit");
      @(posedge sys_clk);
      bus_quiet <= 1'b0;
      if (from_qs) begin
         sysm.stop(1'b0, 0);
      end else begin
         set_brk(6'h02);
         set_brk(6'h00);
      end
      go(NRM, 6);
      chk(clock_state === NRM, "snoop home left");
      $display("test snoop done");
   endtask

   task automatic t_deep(input logic by_clk);
      sysm.stop(1'b1, 0);
      go(QS, 6);
      sysm.deep(by_clk, 1'b1, 0);
      go(DS, 6);
      chk(clock_state === DS && intc_on === 1'b0, "deep entry");
      @(posedge sys_clk);
      snoop_request <= 1'b1;
      @(posedge sys_clk);
      snoop_request <= 1'b0;
      go(SNP, 3);
      chk(clock_state === DS && snoop_grant === 1'b0, "snoop in deep");
      sysm.deep(by_clk, 1'b0, 20);
      go(RL, 26);
      chk(pll_relocking === 1'b1 && clock_state === RL && intc_on === 1'b1, "relock start");
      go(QS, RLC + 4);
      chk(clock_state === QS && n <= RLC && pll_relocking === 1'b0, "relock time");
      sysm.stop(1'b0, 0);
      go(NRM, 6);
      $display("test deep done");
   endtask

   task automatic t_qs_reset;
      sysm.stop(1'b1, 0);
      go(QS, 6);
      set_brk(6'h20);
      set_brk(6'h00);
      #1;
      chk(core_init === 1'b1 && clock_state === QS, "reset in qs");
      go(NRM, 4);
      chk(clock_state === QS && core_init === 1'b0, "stays in qs");
      sysm.stop(1'b0, 0);
      go(NRM, clock_state_pkg::EXIT_LIMIT_CYC);
      chk(clock_state === NRM && core_clk_en === 1'b1, "qs exit");
      $display("test qs_reset done");
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   initial begin
      #200000;
      num_errors++;
      close_out();
   end

   initial begin
      arst_n = 1'b0;
      halt_instruction = 1'b0;
      snoop_request = 1'b0;
      bus_quiet = 1'b0;
      brk = 6'h00;
      num_errors = 0;
      checked = 0;
      repeat (4) @(posedge sys_clk);
      chk(clock_state === NRM && core_clk_en === 1'b1 && counters_en === 1'b1 && snoop_grant === 1'b0, "reset");
      arst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      t_halt();
      t_stop_halt();
      t_snoop(1'b0);
      t_snoop(1'b1);
      t_deep(1'b0);
      t_deep(1'b1);
      t_qs_reset();
      close_out();
   end
endmodule

`default_nettype wire
